// ### include/acs_pkg.sv
// Package with constants and types of the channel scan sequencer.
package acs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_SETTLE   = 4'h1;
  localparam logic [3:0] ADDR_TIMEOUT  = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_RESULT   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h7;
  localparam logic [3:0] ADDR_ZERO_EXP = 4'h8;
  localparam logic [3:0] ADDR_SPAN_EXP = 4'h9;
  localparam logic [3:0] ADDR_CAL_TOL  = 4'hA;
  localparam logic [3:0] ADDR_CHIP_EN  = 4'hB;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_START_POS   = 0;
  localparam int CTRL_REREAD_POS  = 1;
  localparam int CTRL_CH_LSB      = 4;
  localparam int LATCH_CONV_POS   = 1;
  localparam int LATCH_CODE_LSB   = 4;
  localparam int IRQ_DONE_POS     = 0;
  localparam int IRQ_TMO_POS      = 1;
  localparam int IRQ_CAL_POS      = 2;
  localparam int IRQ_BITS         = 3;

  // ****************************************************************
  // Reset values and channel numbers
  // ****************************************************************
  localparam logic [15:0] SETTLE_RESET  = 16'h0040;
  localparam logic [15:0] TIMEOUT_RESET = 16'h1000;
  localparam logic [15:0] ZERO_EXP_RESET = 16'h0000;
  localparam logic [15:0] SPAN_EXP_RESET = 16'hFFFF;
  localparam logic [15:0] CAL_TOL_RESET = 16'h0000;
  localparam logic [2:0]  CHIP_EN_RESET = 3'h7;
  localparam logic [3:0]  CH_ZERO_REF   = 4'hE;
  localparam logic [3:0]  CH_SPAN_REF   = 4'hF;
  localparam logic [3:0]  CH_UPPER_BASE = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH, ST_SETTLE, ST_CONVERT, ST_WAIT, ST_READ_MSB, ST_READ_LSB
  } acs_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } acs_bus_req_t;

  typedef struct packed {
    acs_state_t      state;
    logic [7:0]      latch;
    logic            latchWr;
    logic            lowerGroupEnableN;
    logic            upperGroupEnableN;
    logic            convSelectN;
    logic            byteSelect;
    logic            dataRd;
    logic [3:0]      channel;
    logic [15:0]     settle;
    logic [15:0]     timeout;
    logic [15:0]     count;
    logic [15:0]     result;
    logic [7:0]      msb;
    logic [IRQ_BITS-1:0] irqStat;
    logic [IRQ_BITS-1:0] irqEn;
    logic [15:0]     zeroExp;
    logic [15:0]     spanExp;
    logic [15:0]     calTol;
    logic [2:0]      chipEn;
    logic            statusSync1;
    logic            statusSync2;
    logic            statusPrev;
    logic [15:0]     rdata;
  } acs_state_reg_t;

endpackage : acs_pkg

// ### core/acs_sequencer.sv
// Channel scan sequencer driving an external converter, its latch and decoders.
`timescale 1ns/10ps
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk_sys,           // System clock, 40 MHz.
  input  wire logic        rst,               // Asynchronous reset, active high.
  input  wire logic [3:0]  regAddr,           // Register address.
  input  wire logic [15:0] regWdata,          // Register write data.
  input  wire logic        regWr,             // Register write strobe.
  input  wire logic        regRd,             // Register read strobe.
  output logic      [15:0] regRdata,          // Read data, one cycle after strobe.
  output logic             conversion_done_irq, // Level interrupt.
  output logic      [7:0]  latchData,         // Channel-select latch byte.
  output logic             latchWrite,        // Latch write pulse.
  output logic             lowerGroupEnableN, // Lower buffer enable, active low.
  output logic             upperGroupEnableN, // Upper buffer enable, active low.
  output logic             convSelectN,       // Converter chip select, active low.
  output logic             byteSelectBit,     // Result byte select.
  output logic             dataReadStrobe,    // Converter data read pulse.
  input  wire logic [7:0]  convData,          // Converter data port.
  input  wire logic        conversionStatus,  // Converter status pin, low while busy.
  output logic      [2:0]  chipEnableN        // General output port chip enables.
);

  acs_state_reg_t s_q;
  acs_state_reg_t s_d;
  acs_bus_req_t   req;

  // Returns true when a sixteen-bit reading lies outside expected plus or minus tolerance.
  function automatic logic outOfTol(input logic [15:0] val, input logic [15:0] exp, input logic [15:0] tol);
    logic [15:0] diff;
    diff = (val > exp) ? 16'(val - exp) : 16'(exp - val);
    return diff > tol;
  endfunction : outOfTol

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic risingStatus;
    logic calBad;
    risingStatus = s_q.statusSync2 & ~s_q.statusPrev;
    calBad = 1'b0;
    s_d = s_q;
    s_d.latchWr = 1'b0;
    s_d.dataRd = 1'b0;
    s_d.statusSync1 = conversionStatus;
    s_d.statusSync2 = s_q.statusSync1;
    s_d.statusPrev = s_q.statusSync2;
    s_d.rdata = 16'h0000;

    // Register writes steer the sequencer and its checks.
    if (req.wr) begin
      case (req.addr)
        ADDR_CTRL: begin
          if (s_q.state == ST_IDLE && req.wdata[CTRL_START_POS]) begin
            s_d.channel = req.wdata[CTRL_CH_LSB +: 4];
            s_d.latch = 8'h00;
            s_d.latch[LATCH_CODE_LSB +: 4] = req.wdata[CTRL_CH_LSB +: 4];
            s_d.latch[LATCH_CONV_POS] = 1'b1;
            s_d.latchWr = 1'b1;
            s_d.lowerGroupEnableN = 1'b1;
            s_d.upperGroupEnableN = 1'b1;
            s_d.state = ST_LATCH;
          end else if (s_q.state == ST_IDLE && req.wdata[CTRL_REREAD_POS]) begin
            s_d.count = s_q.settle;
            s_d.state = ST_CONVERT;
          end
        end
        ADDR_SETTLE:   s_d.settle = req.wdata;
        ADDR_TIMEOUT:  s_d.timeout = req.wdata;
        ADDR_IRQ_EN:   s_d.irqEn = req.wdata[IRQ_BITS-1:0];
        ADDR_ZERO_EXP: s_d.zeroExp = req.wdata;
        ADDR_SPAN_EXP: s_d.spanExp = req.wdata;
        ADDR_CAL_TOL:  s_d.calTol = req.wdata;
        ADDR_CHIP_EN:  s_d.chipEn = req.wdata[2:0];
        ADDR_IRQ_CLR:  s_d.irqStat = s_q.irqStat & ~req.wdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // Register reads show the sequencer's own state.
    if (req.rd) begin
      case (req.addr)
        ADDR_CTRL:     s_d.rdata = {8'h00, s_q.channel, 4'h0};
        ADDR_SETTLE:   s_d.rdata = s_q.settle;
        ADDR_TIMEOUT:  s_d.rdata = s_q.timeout;
        ADDR_STATUS:   s_d.rdata = {12'h000, (s_q.state != ST_IDLE), 3'(s_q.state)};
        ADDR_RESULT:   s_d.rdata = s_q.result;
        ADDR_IRQ_STAT: s_d.rdata = {13'h0000, s_q.irqStat};
        ADDR_IRQ_EN:   s_d.rdata = {13'h0000, s_q.irqEn};
        ADDR_ZERO_EXP: s_d.rdata = s_q.zeroExp;
        ADDR_SPAN_EXP: s_d.rdata = s_q.spanExp;
        ADDR_CAL_TOL:  s_d.rdata = s_q.calTol;
        ADDR_CHIP_EN:  s_d.rdata = {13'h0000, s_q.chipEn};
        default:       s_d.rdata = 16'h0000;
      endcase
    end

    // Sequencer walks acquire, convert, wait and read.
    case (s_q.state)
      ST_IDLE: ;
      ST_LATCH: begin
        // The latch pulse is high in this cycle, so the group enable falls in the next, as the pulse ends.
        if (s_q.channel < CH_UPPER_BASE) begin
          s_d.lowerGroupEnableN = 1'b0;
        end else begin
          s_d.upperGroupEnableN = 1'b0;
        end
        // Select stays high while the input is acquired, so no conversion starts early.
        s_d.convSelectN = 1'b1;
        s_d.count = s_q.settle;
        s_d.state = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Converter tracks the input while read/convert and select stay high.
        s_d.convSelectN = 1'b1;
        s_d.latch[LATCH_CONV_POS] = 1'b1;
        if (s_q.count == 16'h0000) begin
          s_d.state = ST_CONVERT;
        end else begin
          s_d.count = 16'(s_q.count - 16'h0001);
        end
      end
      ST_CONVERT: begin
        s_d.latch[LATCH_CONV_POS] = 1'b0;
        s_d.latchWr = 1'b1;
        s_d.convSelectN = 1'b0;
        s_d.count = s_q.timeout;
        s_d.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (risingStatus) begin
          s_d.latch[LATCH_CONV_POS] = 1'b1;
          s_d.latchWr = 1'b1;
          s_d.byteSelect = 1'b0;
          s_d.dataRd = 1'b1;
          s_d.state = ST_READ_MSB;
        end else if (s_q.count == 16'h0000) begin
          s_d.irqStat[IRQ_TMO_POS] = 1'b1;
          s_d.state = ST_IDLE;
        end else begin
          s_d.count = 16'(s_q.count - 16'h0001);
        end
      end
      ST_READ_MSB: begin
        s_d.msb = convData;
        s_d.byteSelect = 1'b1;
        s_d.dataRd = 1'b1;
        s_d.state = ST_READ_LSB;
      end
      ST_READ_LSB: begin
        s_d.result = {s_q.msb, convData};
        s_d.irqStat[IRQ_DONE_POS] = 1'b1;
        if (s_q.channel == CH_ZERO_REF) begin
          calBad = outOfTol({s_q.msb, convData}, s_q.zeroExp, s_q.calTol);
        end else if (s_q.channel == CH_SPAN_REF) begin
          calBad = outOfTol({s_q.msb, convData}, s_q.spanExp, s_q.calTol);
        end
        if (calBad) begin
          s_d.irqStat[IRQ_CAL_POS] = 1'b1;
        end
        s_d.byteSelect = 1'b0;
        s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '{state: ST_IDLE, latch: 8'h00, latchWr: 1'b0, lowerGroupEnableN: 1'b1,
               upperGroupEnableN: 1'b1, convSelectN: 1'b1, byteSelect: 1'b0, dataRd: 1'b0,
               channel: 4'h0, settle: SETTLE_RESET, timeout: TIMEOUT_RESET, count: 16'h0000,
               result: 16'h0000, msb: 8'h00, irqStat: '0, irqEn: '0, zeroExp: ZERO_EXP_RESET,
               spanExp: SPAN_EXP_RESET, calTol: CAL_TOL_RESET, chipEn: CHIP_EN_RESET,
               statusSync1: 1'b1, statusSync2: 1'b1, statusPrev: 1'b1, rdata: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs other than the interrupt come straight from the state register.
  assign regRdata            = s_q.rdata;
  assign conversion_done_irq = |(s_q.irqStat & s_q.irqEn);
  assign latchData           = s_q.latch;
  assign latchWrite          = s_q.latchWr;
  assign lowerGroupEnableN   = s_q.lowerGroupEnableN;
  assign upperGroupEnableN   = s_q.upperGroupEnableN;
  assign convSelectN         = s_q.convSelectN;
  assign byteSelectBit       = s_q.byteSelect;
  assign dataReadStrobe      = s_q.dataRd;
  assign chipEnableN         = s_q.chipEn;

endmodule : acs_sequencer

`default_nettype wire

// ### dv/acs_conv_model.sv
// Behavioural model of the converter that the sequencer drives.
`timescale 1ns/10ps
`default_nettype none
module acs_conv_model #(
  parameter int BUSY = 12
) (
  input  wire logic        clk_sys,          // System clock.
  input  wire logic        rcBit,            // Read/convert line.
  input  wire logic        latchWrite,       // Latch capture pulse.
  input  wire logic        convSelectN,      // Chip select, active low.
  input  wire logic        byteSelectBit,    // Byte select.
  input  wire logic        dataReadStrobe,   // Data read pulse.
  input  wire logic [15:0] sample,           // Analog value at the input.
  input  wire logic        stall,            // Never finish a conversion.
  output logic      [7:0]  convData,         // Data port.
  output logic             conversionStatus  // Status, low while busy.
);
  logic [15:0] held;
  logic [7:0]  junk;
  int          busyCnt;
  initial begin
    conversionStatus = 1'b1;
    junk = 8'h00;
    busyCnt = 0;
    held = 16'h0000;
  end
  // ****************************************************************
  // Conversion and data port
  // ****************************************************************
  // A stalled model keeps status low, which is how a dead converter looks.
  always @(posedge clk_sys) begin
    if (latchWrite && !rcBit && !convSelectN) begin
      held <= sample;
      conversionStatus <= 1'b0;
      busyCnt <= BUSY;
    end else if (busyCnt != 0 && !stall) begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == 1) conversionStatus <= 1'b1;
    end
    junk <= ~junk;
  end
  // The byte stands while the read strobe is high; outside a read a changing pattern shows.
  assign convData = dataReadStrobe ? (byteSelectBit ? held[7:0] : held[15:8]) : junk;
endmodule : acs_conv_model
`default_nettype wire

// ### dv/acs_sequencer_monitor.sv
// Checker of the sequencer's converter-side timing.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_monitor
  import acs_pkg::*;
(
  input wire logic        clk_sys, rst, regWr, latchWrite, convSelectN, // Clock, reset, strobes.
  input wire logic        lowerGroupEnableN, upperGroupEnableN,          // Group enables.
  input wire logic        byteSelectBit, dataReadStrobe, conversionStatus, // Converter lines.
  input wire logic [3:0]  regAddr,                                       // Register address.
  input wire logic [15:0] regWdata,                                      // Write data.
  input wire logic [7:0]  latchData,                                     // Latch byte.
  input wire logic [2:0]  chipEnableN                                    // Chip enables.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_lower;
    $fell(lowerGroupEnableN) |-> $past(latchWrite) && $past(latchData[1]) && !latchData[7];
  endproperty
  a_lower: assert property (p_lower) else $error("lower group enable out of order");
  property p_upper;
    $fell(upperGroupEnableN) |-> $past(latchWrite) && $past(latchData[1]) && latchData[7];
  endproperty
  a_upper: assert property (p_upper) else $error("upper group enable out of order");
  property p_convert;
    latchWrite && !latchData[1] |-> !convSelectN && (lowerGroupEnableN != upperGroupEnableN);
  endproperty
  a_convert: assert property (p_convert) else $error("convert start without select");
  property p_fetch;
    $rose(conversionStatus) && !latchData[1] |-> ##[1:6] latchWrite && latchData[1] && dataReadStrobe;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch after status rise");
  property p_msb_lsb;
    dataReadStrobe && !byteSelectBit |=> dataReadStrobe && byteSelectBit;
  endproperty
  a_msb_lsb: assert property (p_msb_lsb) else $error("second read missing");
  property p_two_only;
    dataReadStrobe && byteSelectBit |=> !dataReadStrobe;
  endproperty
  a_two_only: assert property (p_two_only) else $error("more than two reads");
  property p_read_ctl;
    dataReadStrobe |-> latchData[1] && !convSelectN;
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("read with wrong control");
  property p_chip_en;
    regWr && regAddr == ADDR_CHIP_EN |=> chipEnableN == $past(regWdata[2:0]);
  endproperty
  a_chip_en: assert property (p_chip_en) else $error("chip enables not updated");
endmodule : acs_sequencer_monitor
bind acs_sequencer acs_sequencer_monitor i_mon (.clk_sys, .rst, .regWr, .latchWrite, .convSelectN,
  .lowerGroupEnableN, .upperGroupEnableN, .byteSelectBit, .dataReadStrobe, .conversionStatus,
  .regAddr, .regWdata, .latchData, .chipEnableN);
`default_nettype wire

// ### dv/acs_sequencer_bench.sv
// Self-checking bench of the channel scan sequencer.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_bench;
  import acs_pkg::*;
  logic        clk_sys, rst, regWr, regRd, stall, conversion_done_irq, conversionStatus;
  logic        latchWrite, lowerGroupEnableN, upperGroupEnableN, convSelectN, byteSelectBit, dataReadStrobe;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, sample;
  logic [7:0]  latchData, convData;
  logic [2:0]  chipEnableN;
  int          failures = 0;
  int          n_compared = 0;
  logic [3:0]  chans [4] = '{4'h3, 4'h9, CH_ZERO_REF, CH_SPAN_REF};
  logic [15:0] vals [4] = '{16'hA55A, 16'h3C96, 16'h0B18, 16'h79E0};
  logic [15:0] stat [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0005};
  acs_sequencer i_dut (.clk_sys, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .conversion_done_irq, .latchData, .latchWrite, .lowerGroupEnableN, .upperGroupEnableN,
    .convSelectN, .byteSelectBit, .dataReadStrobe, .convData, .conversionStatus, .chipEnableN);
  acs_conv_model i_adc (.clk_sys, .rcBit(latchData[1]), .latchWrite, .convSelectN, .byteSelectBit,
    .dataReadStrobe, .sample, .stall, .convData, .conversionStatus);
  // Clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(nm, exp, regRdata);
  endtask : rd
  // Bounded wait: a masked conversion simply runs the count out; a dead one stops at the time-out interrupt.
  task automatic scan(input logic [3:0] ch, input logic [1:0] cmd);
    int i;
    wr(ADDR_CTRL, {8'h00, ch, 2'b00, cmd});
    for (i = 0; i < 200 && conversion_done_irq !== 1'b1; i++) @(posedge clk_sys);
  endtask : scan
  task automatic close_out;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #500000;
    failures++;
    close_out();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    sample = 16'h0000;
    stall = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_SETTLE, SETTLE_RESET, "settle");
    rd(ADDR_TIMEOUT, TIMEOUT_RESET, "timeout");
    rd(ADDR_SPAN_EXP, SPAN_EXP_RESET, "span_exp");
    rd(ADDR_CAL_TOL, CAL_TOL_RESET, "cal_tol");
    rd(ADDR_IRQ_STAT, 16'h0000, "irq_stat");
    rd(4'hC, 16'h0000, "unmapped");
    chk("chip_en", {13'h0000, CHIP_EN_RESET}, {13'h0000, chipEnableN});
    wr(ADDR_CHIP_EN, 16'h0005);
    #1 chk("chip_en", 16'h0005, {13'h0000, chipEnableN});
    wr(ADDR_SETTLE, 16'h0004);
    wr(ADDR_ZERO_EXP, 16'h0B18);
    wr(ADDR_IRQ_EN, 16'h0007);
    // Lower, upper, zero reference in tolerance, span reference out of tolerance.
    for (int k = 0; k < 4; k++) begin
      sample <= vals[k];
      scan(chans[k], 2'b01);
      chk("irq", 16'h0001, {15'h0000, conversion_done_irq});
      rd(ADDR_RESULT, vals[k], "result");
      rd(ADDR_IRQ_STAT, stat[k], "irq_stat");
      wr(ADDR_IRQ_CLR, 16'h0007);
      #1 chk("irq_clr", 16'h0000, {15'h0000, conversion_done_irq});
    end
    // Reread of the held sample with the interrupt masked: status still pends.
    wr(ADDR_IRQ_EN, 16'h0000);
    scan(CH_SPAN_REF, 2'b10);
    chk("irq_mask", 16'h0000, {15'h0000, conversion_done_irq});
    rd(ADDR_RESULT, 16'h79E0, "reread");
    rd(ADDR_IRQ_STAT, 16'h0005, "reread_stat");
    // A converter that never finishes must end in the time-out flag.
    wr(ADDR_IRQ_CLR, 16'h0007);
    wr(ADDR_IRQ_EN, 16'h0007);
    wr(ADDR_TIMEOUT, 16'h0020);
    stall <= 1'b1;
    scan(4'h3, 2'b01);
    rd(ADDR_IRQ_STAT, 16'h0002, "timeout_stat");
    close_out();
  end
endmodule : acs_sequencer_bench
`default_nettype wire
